// ==== src/lmds_pkg.sv ====
// constants, types and helpers shared by the led drive mode sequencer
// ==========================================================================
// ==========================================================================
package lmds_pkg;

  // ========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10; // 100 mhz system clock
  localparam int unsigned POR_DELAY_NS = 10000; // least power-on-reset hold
  localparam int unsigned POR_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEAD_NS = 200; // least dead time between outputs
  localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HALF_FREE_CYC = 500; // free-run half period, 100 khz
  localparam int unsigned LOOP_W = 8; // width of loop control level
  localparam int unsigned SYN_W = 16; // width of sync half-cycle timer

  // ========================================================================
  // drive modes, no codes given
  typedef enum logic [1:0] {
    LMDS_MODE_RES,
    LMDS_MODE_PWM,
    LMDS_MODE_SYN
  } lmds_mode_t;

  // enable comparator results: above on, pulse-width and sync thresholds
  typedef struct packed {
    logic syn; // enable above 4.3v
    logic pwm; // enable above 3.2v
    logic on; // enable above 1.7v logic threshold
  } lmds_en_cmp_t;

  // ========================================================================
  // highest threshold passed wins; below pulse-width is resonant
  function automatic lmds_mode_t decode_mode(input lmds_en_cmp_t c);
    if (c.syn) begin
      return LMDS_MODE_SYN;
    end else if (c.pwm) begin
      return LMDS_MODE_PWM;
    end
    return LMDS_MODE_RES;
  endfunction : decode_mode

endpackage : lmds_pkg

// ==== src/lmds_ramp.sv ====
// switching ramp counter: half-period count, phase and boundary pulses
`timescale 1ns/1ps
module lmds_ramp #(
  parameter int unsigned CNT_W = 10
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic clear, // hold ramp at start
  input wire logic [CNT_W-1:0] half_len, // cycles per half period
  output logic [CNT_W-1:0] cnt, // position inside half period
  output logic phase, // 0 first half, 1 second half
  output logic half_end, // last cycle of a half
  output logic period_end // last cycle of a full period
);

  // ========================================================================
  // state
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // ramp position
    logic phase; // half select
  } lmds_ramp_st_t;

  lmds_ramp_st_t r_q; // registered state
  lmds_ramp_st_t r_d; // next state

  // boundary decode, comparator on registered count
  assign half_end = !clear && (r_q.cnt >= half_len - CNT_W'(1));
  assign period_end = half_end && r_q.phase;
  assign cnt = r_q.cnt;
  assign phase = r_q.phase;

  // ========================================================================
  // next ramp; >= keeps a shortened half from running past its end
  always_comb begin
    r_d = r_q;
    if (clear) begin
      r_d = '0;
    end else if (half_end) begin
      r_d.cnt = '0;
      r_d.phase = !r_q.phase;
    end else begin
      r_d.cnt = r_q.cnt + CNT_W'(1);
    end
  end

  // register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

endmodule : lmds_ramp

// ==== src/lmds_sequencer.sv ====
// led drive mode sequencer: power-up sequence, mode select, gate shaping
`timescale 1ns/1ps
module lmds_sequencer #(
  parameter int unsigned HALF_FREE = lmds_pkg::HALF_FREE_CYC, // free-run half period
  parameter int unsigned POR_HOLD = lmds_pkg::POR_CYC // reset hold cycles
) (
  input wire logic sys_clk, // oscillator clock, 100 mhz
  input wire logic rst_b, // async reset, active low
  input wire lmds_pkg::lmds_en_cmp_t en_cmp, // enable level comparators
  input wire logic uvlo_ok, // internal supply above rising threshold
  input wire logic sync_pos, // undervolt_sync_input in positive half
  input wire logic [lmds_pkg::LOOP_W-1:0] loop_level, // loop control level
  output logic regulator_en, // internal supply regulator on
  output logic sleep_mode, // device asleep
  output logic por_active, // power-on reset phase
  output logic logic_clear, // clears counters, registers, fault latch
  output logic softstart_preset, // presets softstart_cap_node
  output logic freq_adj_en, // frequency-adjust current connected
  output lmds_pkg::lmds_mode_t drive_mode, // active drive mode
  output logic gate_drive_a, // first gate output
  output logic gate_drive_b // second gate output
);

  // ========================================================================
  // sizes and elaboration checks
  localparam int unsigned CNT_W = $clog2(HALF_FREE + 1);
  localparam int unsigned POR_W = $clog2(POR_HOLD + 1);
  localparam int unsigned SYN_W = lmds_pkg::SYN_W;
  localparam int unsigned DEAD = lmds_pkg::DEAD_CYC;

  // resonant half must stay above dead time at the top loop level
  if (HALF_FREE < DEAD + (1 << lmds_pkg::LOOP_W) + 2) begin : g_bad_half
    $error("half period too short for dead time plus loop range");
  end
  if (POR_HOLD < 2) begin : g_bad_por
    $error("reset hold must be at least two cycles");
  end

  typedef enum logic [1:0] {
    LMDS_SEQ_SLEEP,
    LMDS_SEQ_LOCK,
    LMDS_SEQ_POR,
    LMDS_SEQ_RUN
  } lmds_seq_t;

  typedef struct packed {
    lmds_seq_t seq; // power-up sequence
    logic [POR_W-1:0] por_cnt; // reset delay timer
    logic [2:0] en_s1; // comparator sync, first stage
    logic [2:0] en_s2; // comparator sync, second stage
    logic sync_s1; // sync waveform, first stage
    logic sync_s2; // sync waveform, second stage
    logic sync_s3; // delayed copy for edge detect
    lmds_pkg::lmds_mode_t mode; // active drive mode
    logic [SYN_W-1:0] syn_cnt; // cycles since last zero crossing
    logic [SYN_W-1:0] syn_len; // length of previous half cycle
    logic gate_a; // gate output a
    logic gate_b; // gate output b
  } lmds_state_t;

  lmds_state_t s_q; // registered state
  lmds_state_t s_d; // next state

  logic [CNT_W-1:0] half_len; // ramp half length for current mode
  logic [CNT_W-1:0] rcnt; // ramp position
  logic rphase; // ramp half
  logic period_end; // switching period boundary
  logic running; // normal operation
  logic sync_edge; // zero crossing of sync waveform
  lmds_pkg::lmds_en_cmp_t en_s; // synchronised comparators

  assign running = (s_q.seq == LMDS_SEQ_RUN);
  assign en_s = lmds_pkg::lmds_en_cmp_t'(s_q.en_s2);
  assign sync_edge = s_q.sync_s2 ^ s_q.sync_s3;

  // ========================================================================
  // ramp: resonant shortens half period as loop level rises
  always_comb begin
    if (s_q.mode == lmds_pkg::LMDS_MODE_RES) begin
      half_len = CNT_W'(HALF_FREE) - CNT_W'(loop_level);
    end else begin
      half_len = CNT_W'(HALF_FREE);
    end
  end

  // one oscillator clock drives the ramp and every timer
  lmds_ramp #(
    .CNT_W(CNT_W)
  ) i_lmds_ramp (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clear(!running),
    .half_len(half_len),
    .cnt(rcnt),
    .phase(rphase),
    .half_end(),
    .period_end(period_end)
  );

  // ========================================================================
  // next state: sequence, mode and gate shaping
  always_comb begin
    logic on;
    on = 1'b0;
    s_d = s_q;
    // comparators and sync waveform pass two flops first
    s_d.en_s1 = {en_cmp.syn, en_cmp.pwm, en_cmp.on};
    s_d.en_s2 = s_q.en_s1;
    s_d.sync_s1 = sync_pos;
    s_d.sync_s2 = s_q.sync_s1;
    s_d.sync_s3 = s_q.sync_s2;

    // power-up sequence
    case (s_q.seq)
      LMDS_SEQ_SLEEP: begin
        if (en_s.on) begin
          s_d.seq = LMDS_SEQ_LOCK;
        end
      end
      LMDS_SEQ_LOCK: begin
        if (!en_s.on) begin
          s_d.seq = LMDS_SEQ_SLEEP;
        end else if (uvlo_ok) begin
          s_d.seq = LMDS_SEQ_POR;
          s_d.por_cnt = '0;
        end
      end
      LMDS_SEQ_POR: begin
        if (!en_s.on) begin
          s_d.seq = LMDS_SEQ_SLEEP;
        end else if (!uvlo_ok) begin
          s_d.seq = LMDS_SEQ_LOCK;
        end else if (s_q.por_cnt == POR_W'(POR_HOLD - 1)) begin
          s_d.seq = LMDS_SEQ_RUN;
        end else begin
          s_d.por_cnt = s_q.por_cnt + POR_W'(1);
        end
      end
      LMDS_SEQ_RUN: begin
        if (!en_s.on) begin
          s_d.seq = LMDS_SEQ_SLEEP;
        end else if (!uvlo_ok) begin
          s_d.seq = LMDS_SEQ_LOCK; // supply dip falls back to lockout
        end
      end
      default: begin
        s_d.seq = LMDS_SEQ_SLEEP;
      end
    endcase

    // mode follows enable on any cycle outside run, in run only at a period end, so no resonant or pulse-width pulse is cut short
    if (!running || period_end) begin
      s_d.mode = lmds_pkg::decode_mode(en_s);
    end

    // half-cycle timer of the sync waveform, saturating
    if (!running || sync_edge) begin
      s_d.syn_cnt = '0;
      s_d.syn_len = running ? s_q.syn_cnt : '0;
    end else if (s_q.syn_cnt != '1) begin
      s_d.syn_cnt = s_q.syn_cnt + SYN_W'(1);
    end

    // gate shaping; outside run both stay low
    s_d.gate_a = 1'b0;
    s_d.gate_b = 1'b0;
    if (running) begin
      case (s_q.mode)
        lmds_pkg::LMDS_MODE_RES: begin
          on = (rcnt >= CNT_W'(DEAD));
          s_d.gate_a = on && !rphase;
          s_d.gate_b = on && rphase;
        end
        lmds_pkg::LMDS_MODE_PWM: begin
          // trailing edge: rises after dead time, width from loop
          on = (rcnt >= CNT_W'(DEAD)) &&
               (rcnt < CNT_W'(DEAD) + CNT_W'(loop_level));
          s_d.gate_a = on && !rphase;
          s_d.gate_b = on && rphase;
        end
        lmds_pkg::LMDS_MODE_SYN: begin
          // leading edge: ends at zero crossing, starts width before it
          on = !sync_edge && (s_q.syn_cnt >= SYN_W'(DEAD)) &&
               ({1'b0, s_q.syn_cnt} + (SYN_W + 1)'(loop_level) >=
                {1'b0, s_q.syn_len});
          s_d.gate_a = on && s_q.sync_s2;
          s_d.gate_b = on && !s_q.sync_s2;
        end
        default: begin
          s_d.gate_a = 1'b0;
          s_d.gate_b = 1'b0;
        end
      endcase
    end
  end

  // register; everything starts asleep with both gate outputs low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // outputs, decoded from registered state
  assign regulator_en = (s_q.seq != LMDS_SEQ_SLEEP);
  assign sleep_mode = (s_q.seq == LMDS_SEQ_SLEEP);
  assign por_active = (s_q.seq == LMDS_SEQ_POR);
  assign logic_clear = !running;
  assign softstart_preset = !running;
  assign freq_adj_en = running && (s_q.mode == lmds_pkg::LMDS_MODE_RES);
  assign drive_mode = s_q.mode;
  assign gate_drive_a = s_q.gate_a;
  assign gate_drive_b = s_q.gate_b;

  // ========================================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_sleep_reg_off: assert property ((!en_s.on && !por_active) |=> !regulator_en)
    else $error("regulator on without enable");
  a_lockout_release: assert property (
    (s_q.seq == LMDS_SEQ_LOCK && en_s.on && uvlo_ok) |=> por_active && s_q.por_cnt == '0)
    else $error("lockout not released into reset");
  a_por_outputs_idle: assert property (
    por_active |-> (!gate_drive_a && !gate_drive_b && softstart_preset && logic_clear))
    else $error("outputs active during reset");
  a_por_full_delay: assert property (
    (running && $past(por_active)) |-> $past(s_q.por_cnt) == POR_W'(POR_HOLD - 1))
    else $error("reset released early");
  a_mode_on_boundary: assert property (
    ($past(running) && running && (s_q.mode != $past(s_q.mode))) |-> $past(period_end))
    else $error("mode switched inside a period");
  a_no_overlap: assert property (!(gate_drive_a && gate_drive_b))
    else $error("both gate outputs on");
  a_dead_after_a: assert property ($fell(gate_drive_a) |-> !gate_drive_b [*8])
    else $error("dead time violated after output a");
  // every way for a to rise passes a count of at least the dead time
  a_dead_after_b: assert property ($fell(gate_drive_b) |-> !gate_drive_a [*8])
    else $error("dead time violated after output b");
  a_freq_adj_mode: assert property (
    freq_adj_en |-> drive_mode == lmds_pkg::LMDS_MODE_RES)
    else $error("frequency adjust outside resonant mode");
  a_sync_halves: assert property (
    (drive_mode == lmds_pkg::LMDS_MODE_SYN && gate_drive_a) |-> $past(s_q.sync_s2))
    else $error("output a outside positive half");
  a_res_full_duty: assert property (
    (running && s_q.mode == lmds_pkg::LMDS_MODE_RES && rcnt == CNT_W'(DEAD) + CNT_W'(1))
    |-> (gate_drive_a ^ gate_drive_b))
    else $error("resonant output not on after dead time");

  c_reach_run: cover property (por_active ##1 running);
  c_mode_pwm: cover property (running && drive_mode == lmds_pkg::LMDS_MODE_PWM && gate_drive_b);
  c_mode_syn: cover property (running && drive_mode == lmds_pkg::LMDS_MODE_SYN && gate_drive_a);
  c_mode_res: cover property (
    running && drive_mode == lmds_pkg::LMDS_MODE_RES && $rose(gate_drive_b));

endmodule : lmds_sequencer

// ==== dv/lmds_sync_src.sv ====
// far-side model: power supply sync waveform feeding undervolt_sync_input
`timescale 1ns/1ps
module lmds_sync_src (
  input wire logic sys_clk, // bench clock
  input wire logic run, // supply running in sync mode
  input wire logic [15:0] half_len, // cycles per sync half-cycle
  output logic sync_pos // high in positive half
);
  logic [15:0] cnt_q; // position inside half-cycle
  // ==========================================================
  // square sync wave; stands low when the supply is stopped
  always @(posedge sys_clk) begin
    if (!run) begin
      cnt_q <= 16'h0000;
      sync_pos <= 1'b0;
    end else if (cnt_q + 16'h0001 >= half_len) begin
      cnt_q <= 16'h0000;
      sync_pos <= ~sync_pos;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule : lmds_sync_src

// ==== dv/lmds_sequencer_tb.sv ====
// self-checking bench for the led drive mode sequencer
`timescale 1ns/1ps
module lmds_sequencer_tb;
  localparam int HF = 300; // shortened free-run half period
  localparam int PH = 4; // shortened reset hold
  localparam int DT = 20; // dead time cycles
  logic sys_clk = 1'b0; // system clock
  logic rst_b = 1'b0; // reset, active low
  lmds_pkg::lmds_en_cmp_t en_cmp = 3'h0; // enable comparators
  logic uvlo_ok = 1'b0; // supply good
  logic [7:0] loop_level = 8'h00; // loop control level
  logic syn_on = 1'b0; // partner sync running
  logic [15:0] syn_half = 16'h0190; // partner half-cycle
  logic sync_pos, regulator_en, sleep_mode, por_active, logic_clear;
  logic softstart_preset, freq_adj_en, gate_drive_a, gate_drive_b;
  lmds_pkg::lmds_mode_t drive_mode; // active mode
  int failures = 0; // mismatch count
  int comparisons = 0; // comparison count
  int cycles = 0; // timeout counter
  int w, p, n; // measured widths and periods

  lmds_sequencer #(.HALF_FREE(HF), .POR_HOLD(PH)) i_lmds_sequencer (
    .sys_clk(sys_clk), .rst_b(rst_b), .en_cmp(en_cmp), .uvlo_ok(uvlo_ok),
    .sync_pos(sync_pos), .loop_level(loop_level), .regulator_en(regulator_en),
    .sleep_mode(sleep_mode), .por_active(por_active), .logic_clear(logic_clear),
    .softstart_preset(softstart_preset), .freq_adj_en(freq_adj_en),
    .drive_mode(drive_mode), .gate_drive_a(gate_drive_a), .gate_drive_b(gate_drive_b));
  lmds_sync_src i_lmds_sync_src (.sys_clk(sys_clk), .run(syn_on),
    .half_len(syn_half), .sync_pos(sync_pos));

  // ==========================================================
  // clock, timeout and overlap watch
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      summarize();
    end
  end
  always @(negedge sys_clk) begin
    if (gate_drive_a === 1'b1 && gate_drive_b === 1'b1) check("overlap", 1, 0);
  end

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc
  function automatic logic g(input logic s);
    return s ? gate_drive_b : gate_drive_a;
  endfunction : g
  // width and period of one gate pulse, bounded waits
  task automatic pulse(input logic s, output int wd, output int pd);
    int k;
    k = 0;
    while (g(s) !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
    wd = 0;
    while (g(s) === 1'b1 && wd < 3000) begin
      cyc(1);
      wd++;
    end
    pd = wd;
    while (g(s) !== 1'b1 && pd < 3000) begin
      cyc(1);
      pd++;
    end
  endtask : pulse
  task automatic wait_mode(input lmds_pkg::lmds_mode_t m);
    int k;
    k = 0;
    while (drive_mode !== m && k < 2 * HF + 20) begin
      cyc(1);
      k++;
    end
  endtask : wait_mode
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // scenarios
  task automatic t_power();
    check("sleep", sleep_mode, 1);
    check("clear", {logic_clear, softstart_preset, gate_drive_a, gate_drive_b}, 4'hc);
    uvlo_ok = 1'b0;
    en_cmp.on = 1'b1;
    cyc(2);
    check("reg early", regulator_en, 0);
    cyc(1);
    check("reg on", regulator_en, 1);
    cyc(5);
    check("lockout", {por_active, logic_clear}, 2'h1);
    uvlo_ok = 1'b1;
    cyc(1);
    check("por start", por_active, 1);
    cyc(PH - 1);
    check("por hold", {por_active, logic_clear, gate_drive_a}, 3'h6);
    cyc(1);
    check("por end", {por_active, logic_clear}, 2'h0);
    $display("test power done");
  endtask : t_power
  task automatic t_res();
    pulse(0, w, p);
    check("res width", w[15:0], HF - DT);
    check("res period", p[15:0], 2 * HF);
    check("freq adj", freq_adj_en, 1);
    check("res mode", drive_mode, lmds_pkg::LMDS_MODE_RES);
    n = 0;
    while (gate_drive_b !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    check("half apart", n[15:0], HF);
    loop_level = 8'h64;
    pulse(0, w, p);
    pulse(0, w, p);
    check("res fast width", w[15:0], HF - 100 - DT);
    check("res fast period", p[15:0], 2 * (HF - 100));
    $display("test resonant done");
  endtask : t_res
  task automatic t_pwm();
    loop_level = 8'h32;
    en_cmp.pwm = 1'b1;
    wait_mode(lmds_pkg::LMDS_MODE_PWM);
    check("pwm mode", drive_mode, lmds_pkg::LMDS_MODE_PWM);
    pulse(0, w, p);
    pulse(0, w, p);
    check("pwm width a", w[15:0], 50);
    check("pwm period", p[15:0], 2 * HF);
    check("freq fixed", freq_adj_en, 0);
    pulse(1, w, p);
    check("pwm width b", w[15:0], 50);
    $display("test pwm done");
  endtask : t_pwm
  task automatic t_syn(input logic [15:0] hl);
    int bad;
    loop_level = 8'h3c;
    syn_half = hl;
    syn_on = 1'b1;
    en_cmp.syn = 1'b1;
    wait_mode(lmds_pkg::LMDS_MODE_SYN);
    check("syn mode", drive_mode, lmds_pkg::LMDS_MODE_SYN);
    repeat (3) pulse(0, w, p);
    check("syn period", p[15:0], 2 * hl);
    check("syn width", (w >= 55 && w <= 66), 1);
    bad = 0;
    repeat (4 * hl) begin
      cyc(1);
      if ((gate_drive_a === 1'b1) == (sync_pos !== 1'b1) && (gate_drive_a | gate_drive_b)) bad++;
    end
    check("syn halves", bad <= 16, 1);
    $display("test sync done");
  endtask : t_syn
  task automatic t_dip();
    uvlo_ok = 1'b0;
    cyc(2);
    check("dip clear", {logic_clear, gate_drive_a, gate_drive_b}, 3'h4);
    uvlo_ok = 1'b1;
    cyc(PH + 2);
    check("dip rerun", logic_clear, 0);
    en_cmp = 3'h0;
    cyc(6);
    check("asleep", {sleep_mode, regulator_en}, 2'h2);
    $display("test dip done");
  endtask : t_dip

  initial begin
    cyc(8);
    rst_b = 1'b1;
    cyc(2);
    t_power();
    t_res();
    t_pwm();
    t_syn(16'h0190);
    t_syn(16'h0258);
    t_dip();
    summarize();
  end
endmodule : lmds_sequencer_tb
